// ---- rtl/bavr_regs.sv ----
// bavr_regs: verb register bank for the beep widget and vendor amp widget.
// assumes verbs arrive one per frame on the link clock, already decoded;
// the response is returned on the link clock one cycle after the verb.
`timescale 1ns/100ps

module bavr_regs (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_link_clk,
  input  wire logic        i_fg_reset,
  input  wire logic        i_verb_valid,
  input  wire logic [6:0]  i_verb_nid,
  input  wire logic [11:0] i_verb_id,
  input  wire logic [7:0]  i_verb_payload,
  input  wire logic        i_frame_sync,
  input  wire logic        i_ch0_saturation,
  input  wire logic        i_ch1_saturation,
  input  wire logic        i_sample_strobe,
  input  wire logic        i_sample_zero,
  input  wire logic [3:0]  i_pin_out_en,
  output logic             o_resp_valid,
  output logic [31:0]      o_resp_data,
  output logic [3:0]       o_beep_pins,
  output logic             o_beep_active,
  output logic [2:0]       o_beep_dgain,
  output logic             o_beep_mute,
  output logic [1:0]       o_beep_amp_gain,
  output logic [7:0]       o_spk_level_left,
  output logic [7:0]       o_spk_level_right,
  output logic [7:0]       o_datapath_init,
  output logic [7:0]       o_amp_config,
  output logic [7:0]       o_amp_power_misc,
  output logic             o_zero_mute
);
  // ----------------------------------------------------------------
  // link domain state: registers, beep generator, zero-run counter
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        resp_valid;
    logic [31:0] resp_data;
    logic [7:0]  tone_div;
    logic [2:0]  dgain;
    logic        amp_mute;
    logic [1:0]  amp_gain;
    logic [1:0]  pwr_set;
    logic [1:0]  pwr_act;
    logic        pwr_err;
    logic        settings_clr;
    logic [7:0]  vol_l;
    logic [7:0]  vol_r;
    logic [7:0]  amp_power_misc;
    logic [7:0]  srst;
    logic [7:0]  init;
    logic [7:0]  config_r;
    logic [7:0]  gclo;
    logic [1:0]  zdet_sel;
    logic        sat0_held;
    logic        sat1_held;
    logic        zero_flag;
    logic [11:0] zero_run;
    logic [9:0]  tone_cnt;
    logic        tone;
    logic [3:0]  beep_pins;
  } bavr_link_type;

  bavr_link_type l_reg;
  bavr_link_type l_next;

  // ----------------------------------------------------------------
  // synchronisers: core-clock reset and async status into link domain
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic [1:0] sat0_sync_reg;
  logic [1:0] sat1_sync_reg;
  logic       link_rst;

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_sync_reg  <= 2'b11;
      sat0_sync_reg <= 2'b00;
      sat1_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg  <= {rst_sync_reg[0], 1'b0};
      sat0_sync_reg <= {sat0_sync_reg[0], i_ch0_saturation};
      sat1_sync_reg <= {sat1_sync_reg[0], i_ch1_saturation};
    end
  end
  assign link_rst = rst_sync_reg[1];

  function automatic logic [11:0] zrun_limit(input logic [1:0] sel);
    unique case (sel)
      2'd0: zrun_limit = bavr_pkg::ZRUN_T0;
      2'd1: zrun_limit = bavr_pkg::ZRUN_T1;
      2'd2: zrun_limit = bavr_pkg::ZRUN_T2;
      2'd3: zrun_limit = bavr_pkg::ZRUN_T3;
    endcase
  endfunction

  function automatic bavr_link_type amp_defaults(input bavr_link_type s);
    bavr_link_type d;
    d           = s;
    d.vol_l     = bavr_pkg::VOL_RST;
    d.vol_r     = bavr_pkg::VOL_RST;
    d.amp_power_misc      = bavr_pkg::AMP_POWER_MISC_RST;
    d.srst      = 8'h00;
    d.init      = bavr_pkg::INIT_RST;
    d.config_r  = bavr_pkg::CFG_RST;
    d.gclo      = bavr_pkg::GCLO_RST;
    d.zdet_sel  = bavr_pkg::ZDET_RST;
    d.sat0_held = 1'b0;
    d.sat1_held = 1'b0;
    d.zero_flag = 1'b0;
    d.zero_run  = 12'h000;
    amp_defaults = d;
  endfunction

  logic is_beep;
  logic is_vend;
  logic is_set;
  logic sat0_now;
  logic sat1_now;

  always_comb begin
    l_next            = l_reg;
    l_next.resp_valid = 1'b0;
    is_beep  = i_verb_valid && (i_verb_nid == bavr_pkg::NID_BEEP);
    is_vend  = i_verb_valid && (i_verb_nid == bavr_pkg::NID_VENDOR);
    is_set   = (i_verb_id[11:8] == 4'h7) || (i_verb_id[11:8] == bavr_pkg::VERB_SET_AMP_HI);
    sat0_now = sat0_sync_reg[1];
    sat1_now = sat1_sync_reg[1];

    // ----------------------------------------------------------------
    // beep widget verbs
    // ----------------------------------------------------------------
    if (is_beep) begin
      l_next.resp_valid = 1'b1;
      l_next.resp_data  = 32'h0000_0000;
      if (is_set) begin
        l_next.settings_clr = 1'b0;
      end
      if (i_verb_id == bavr_pkg::VERB_GET_PARAM) begin
        if (i_verb_payload == bavr_pkg::PARAM_BEEP_WIDGET_CAPS) begin
          l_next.resp_data = bavr_pkg::BEEP_BEEP_WIDGET_CAPS_VAL;
        end else if (i_verb_payload == bavr_pkg::PARAM_OUTAMP) begin
          l_next.resp_data = bavr_pkg::BEEP_AMPCAP_VAL;
        end
      end else if (i_verb_id == bavr_pkg::VERB_GET_PWR) begin
        l_next.resp_data = {21'h0, l_reg.settings_clr, 1'b0, l_reg.pwr_err,
                            2'b00, l_reg.pwr_act, 2'b00, l_reg.pwr_set};
        l_next.settings_clr = 1'b0;
      end else if (i_verb_id == bavr_pkg::VERB_SET_PWR) begin
        l_next.pwr_set = i_verb_payload[1:0];
        // every state the widget can request is reachable, so no error
        l_next.pwr_act = i_verb_payload[1:0];
        l_next.pwr_err = 1'b0;
      end else if (i_verb_id == bavr_pkg::VERB_GET_TONE) begin
        l_next.resp_data = {24'h0, l_reg.tone_div};
      end else if (i_verb_id == bavr_pkg::VERB_SET_TONE) begin
        l_next.tone_div = i_verb_payload;
      end else if (i_verb_id == bavr_pkg::VERB_GET_DGAIN) begin
        l_next.resp_data = {29'h0, l_reg.dgain};
      end else if (i_verb_id == bavr_pkg::VERB_SET_DGAIN) begin
        // codes above +6 dB are not defined, so they are dropped
        if (i_verb_payload[2:0] <= bavr_pkg::DGAIN_MAX) begin
          l_next.dgain = i_verb_payload[2:0];
        end
      end else if (i_verb_id == bavr_pkg::VERB_GET_AMP) begin
        l_next.resp_data = {24'h0, l_reg.amp_mute, 5'h00, l_reg.amp_gain};
      end else if (i_verb_id[11:8] == bavr_pkg::VERB_SET_AMP_HI) begin
        l_next.amp_mute = i_verb_payload[bavr_pkg::AMP_MUTE_BIT];
        l_next.amp_gain = i_verb_payload[1:0];
      end
    end

    // ----------------------------------------------------------------
    // vendor amp verbs: get is F7x..F9x, set is 77x..79x
    // ----------------------------------------------------------------
    if (is_vend) begin
      l_next.resp_valid = 1'b1;
      l_next.resp_data  = 32'h0000_0000;
      if (i_verb_id == bavr_pkg::VERB_GET_PARAM) begin
        if (i_verb_payload == bavr_pkg::PARAM_BEEP_WIDGET_CAPS) begin
          l_next.resp_data = bavr_pkg::VEND_BEEP_WIDGET_CAPS_VAL;
        end
      end else if (i_verb_id[11:8] == 4'hF) begin
        unique case ({4'h7, i_verb_id[7:0]})
          bavr_pkg::VERB_SET_VOL_L:  l_next.resp_data[7:0] = l_reg.vol_l;
          bavr_pkg::VERB_SET_VOL_R:  l_next.resp_data[7:0] = l_reg.vol_r;
          bavr_pkg::VERB_SET_AMP_POWER_MISC:   l_next.resp_data[7:0] = l_reg.amp_power_misc;
          bavr_pkg::VERB_SET_SRST:   l_next.resp_data[7:0] = l_reg.srst;
          bavr_pkg::VERB_SET_STATUS: l_next.resp_data[7:0] =
            {l_reg.sat1_held, l_reg.sat0_held, 3'b000, sat1_now, sat0_now,
             l_reg.zero_flag};
          bavr_pkg::VERB_SET_INIT:   l_next.resp_data[7:0] = l_reg.init;
          bavr_pkg::VERB_SET_CONFIG: l_next.resp_data[7:0] = l_reg.config_r;
          bavr_pkg::VERB_SET_ZDET:   l_next.resp_data[7:0] =
            {3'b000, l_reg.zdet_sel, 3'b000};
          bavr_pkg::VERB_SET_GCLO:   l_next.resp_data[7:0] = l_reg.gclo;
          default:                   l_next.resp_data[7:0] = 8'h00;
        endcase
      end else begin
        unique case (i_verb_id)
          bavr_pkg::VERB_SET_VOL_L:  l_next.vol_l = i_verb_payload;
          bavr_pkg::VERB_SET_VOL_R:  l_next.vol_r = i_verb_payload;
          bavr_pkg::VERB_SET_VOL_LR: begin
            l_next.vol_l = i_verb_payload;
            l_next.vol_r = i_verb_payload;
          end
          bavr_pkg::VERB_SET_AMP_POWER_MISC:   l_next.amp_power_misc = (i_verb_payload & bavr_pkg::AMP_POWER_MISC_WMASK)
                                                   | bavr_pkg::AMP_POWER_MISC_RST;
          bavr_pkg::VERB_SET_SRST:   l_next = amp_defaults(l_next);
          bavr_pkg::VERB_SET_INIT:   l_next.init = i_verb_payload
                                                   & bavr_pkg::INIT_WMASK;
          bavr_pkg::VERB_SET_CONFIG: l_next.config_r = i_verb_payload
                                                       & bavr_pkg::CFG_WMASK;
          bavr_pkg::VERB_SET_ZDET:   l_next.zdet_sel = i_verb_payload[4:3];
          bavr_pkg::VERB_SET_GCLO:   l_next.gclo = i_verb_payload
                                                   & bavr_pkg::GCLO_WMASK;
          default: ;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // status flags: hardware set is applied after clear so it wins
    // ----------------------------------------------------------------
    if (is_vend && (i_verb_id == bavr_pkg::VERB_SET_GCLO)
        && i_verb_payload[bavr_pkg::GCLO_CLR_BIT]) begin
      l_next.sat0_held = 1'b0;
      l_next.sat1_held = 1'b0;
    end
    if (sat0_now) begin
      l_next.sat0_held = 1'b1;
    end
    if (sat1_now) begin
      l_next.sat1_held = 1'b1;
    end
    if (i_sample_strobe) begin
      if (!i_sample_zero) begin
        l_next.zero_run  = 12'h000;
        l_next.zero_flag = 1'b0;
      end else if (l_reg.zero_run >= zrun_limit(l_reg.zdet_sel)) begin
        l_next.zero_flag = 1'b1;
      end else begin
        l_next.zero_run = l_reg.zero_run + 12'd1;
      end
    end

    // ----------------------------------------------------------------
    // beep tone: toggle every 2*divider frames, period 4*divider frames
    // ----------------------------------------------------------------
    if (l_reg.tone_div == 8'h00) begin
      l_next.tone     = 1'b0;
      l_next.tone_cnt = 10'h000;
    end else if (i_frame_sync) begin
      if (l_reg.tone_cnt >= ({2'b00, l_reg.tone_div} * 10'(bavr_pkg::TONE_HALF_MULT))
                            - 10'd1) begin
        l_next.tone_cnt = 10'h000;
        l_next.tone     = ~l_reg.tone;
      end else begin
        l_next.tone_cnt = l_reg.tone_cnt + 10'd1;
      end
    end
    l_next.beep_pins = (l_reg.tone_div != 8'h00) ? ({4{l_reg.tone}} & i_pin_out_en)
                                                 : 4'h0;

    // function group reset restores all widget defaults
    if (i_fg_reset) begin
      l_next              = amp_defaults(l_next);
      l_next.tone_div     = 8'h00;
      l_next.dgain        = bavr_pkg::DGAIN_RST;
      l_next.amp_mute     = 1'b0;
      l_next.amp_gain     = bavr_pkg::AMP_GAIN_RST;
      l_next.pwr_set      = 2'b00;
      l_next.pwr_act      = bavr_pkg::PWR_ACT_RST;
      l_next.pwr_err      = 1'b0;
      l_next.settings_clr = 1'b1;
    end

    // hold reset values until the released reset has passed the synchroniser
    if (link_rst) begin
      l_next = l_reg;
    end
  end

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      l_reg              <= '0;
      l_reg.dgain        <= bavr_pkg::DGAIN_RST;
      l_reg.amp_gain     <= bavr_pkg::AMP_GAIN_RST;
      l_reg.pwr_act      <= bavr_pkg::PWR_ACT_RST;
      l_reg.settings_clr <= 1'b1;
      l_reg.vol_l        <= bavr_pkg::VOL_RST;
      l_reg.vol_r        <= bavr_pkg::VOL_RST;
      l_reg.amp_power_misc         <= bavr_pkg::AMP_POWER_MISC_RST;
      l_reg.init         <= bavr_pkg::INIT_RST;
      l_reg.gclo         <= bavr_pkg::GCLO_RST;
      l_reg.zdet_sel     <= bavr_pkg::ZDET_RST;
      l_reg.config_r     <= bavr_pkg::CFG_RST;
    end else begin
      l_reg <= l_next;
    end
  end

  // ----------------------------------------------------------------
  // core domain: settings cross as one word, taken once it is stable
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [47:0] s1;
    logic [47:0] s2;
    logic [47:0] s3;
    logic [47:0] word;
  } bavr_core_type;

  bavr_core_type c_reg;
  bavr_core_type c_next;

  always_comb begin
    c_next    = c_reg;
    c_next.s1 = {l_reg.vol_l, l_reg.vol_r, l_reg.init, l_reg.config_r, l_reg.amp_power_misc,
                 l_reg.tone_div != 8'h00, l_reg.dgain, l_reg.amp_mute, l_reg.amp_gain,
                 l_reg.zero_flag & l_reg.gclo[2]};
    c_next.s2 = c_reg.s1;
    c_next.s3 = c_reg.s2;
    // a word is taken only when two synchronised samples agree, so a sample
    // caught mid-change never reaches the outputs; relies on the link clock
    // being slower than the core clock, so two samples cannot both straddle
    if (c_reg.s3 == c_reg.s2) begin
      c_next.word = c_reg.s3;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  assign o_resp_valid      = l_reg.resp_valid;
  assign o_resp_data       = l_reg.resp_data;
  assign o_beep_pins       = l_reg.beep_pins;
  assign o_beep_active     = c_reg.word[7];
  assign o_beep_dgain      = c_reg.word[6:4];
  assign o_beep_mute       = c_reg.word[3];
  assign o_beep_amp_gain   = c_reg.word[2:1];
  assign o_spk_level_left  = c_reg.word[47:40];
  assign o_spk_level_right = c_reg.word[39:32];
  assign o_datapath_init   = c_reg.word[31:24];
  assign o_amp_config      = c_reg.word[23:16];
  assign o_amp_power_misc  = c_reg.word[15:8];
  assign o_zero_mute       = c_reg.word[0];
endmodule

// ---- rtl/bavr_pkg.sv ----
// bavr_pkg: verb codes, field positions, reset values and timing for the
// beep widget and the vendor amplifier register bank.
// assumes a verb decoder upstream delivers node id, 12-bit verb and 8-bit payload.
package bavr_pkg;
  // ----------------------------------------------------------------
  // node ids
  // ----------------------------------------------------------------
  localparam logic [6:0]  NID_BEEP        = 7'h19;
  localparam logic [6:0]  NID_VENDOR      = 7'h1A;
  // ----------------------------------------------------------------
  // verbs (12-bit verb id, payload separate)
  // ----------------------------------------------------------------
  localparam logic [11:0] VERB_GET_PARAM  = 12'hF00;
  localparam logic [11:0] VERB_GET_PWR    = 12'hF05;
  localparam logic [11:0] VERB_SET_PWR    = 12'h705;
  localparam logic [11:0] VERB_GET_TONE   = 12'hF0A;
  localparam logic [11:0] VERB_SET_TONE   = 12'h70A;
  localparam logic [11:0] VERB_GET_DGAIN  = 12'hF7A;
  localparam logic [11:0] VERB_SET_DGAIN  = 12'h77A;
  localparam logic [11:0] VERB_GET_AMP    = 12'hBA0;
  localparam logic [3:0]  VERB_SET_AMP_HI = 4'h3;
  localparam logic [11:0] VERB_SET_VOL_L  = 12'h771;
  localparam logic [11:0] VERB_SET_VOL_R  = 12'h772;
  localparam logic [11:0] VERB_SET_VOL_LR = 12'h773;
  localparam logic [11:0] VERB_SET_AMP_POWER_MISC   = 12'h779;
  localparam logic [11:0] VERB_SET_SRST   = 12'h77F;
  localparam logic [11:0] VERB_SET_STATUS = 12'h780;
  localparam logic [11:0] VERB_SET_INIT   = 12'h781;
  localparam logic [11:0] VERB_SET_CONFIG = 12'h782;
  localparam logic [11:0] VERB_SET_ZDET   = 12'h790;
  localparam logic [11:0] VERB_SET_GCLO   = 12'h791;
  localparam logic [7:0]  PARAM_BEEP_WIDGET_CAPS      = 8'h09;
  localparam logic [7:0]  PARAM_OUTAMP    = 8'h12;
  // ----------------------------------------------------------------
  // constant responses
  // ----------------------------------------------------------------
  localparam logic [31:0] BEEP_BEEP_WIDGET_CAPS_VAL   = 32'h0070_040C;
  localparam logic [31:0] BEEP_AMPCAP_VAL = 32'h8017_0303;
  localparam logic [31:0] VEND_BEEP_WIDGET_CAPS_VAL   = 32'h00F0_0001;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          AMP_MUTE_BIT    = 7;
  localparam int          PWR_ERR_BIT     = 8;
  localparam int          PWR_CLR_BIT     = 10;
  localparam int          GCLO_CLR_BIT    = 7;
  localparam logic [1:0]  AMP_GAIN_RST    = 2'h1;
  localparam logic [1:0]  PWR_ACT_RST     = 2'h3;
  localparam logic [2:0]  DGAIN_RST       = 3'h5;
  localparam logic [2:0]  DGAIN_MAX       = 3'h5;
  localparam logic [7:0]  VOL_RST         = 8'h30;
  localparam logic [7:0]  AMP_POWER_MISC_RST        = 8'h02;
  localparam logic [7:0]  AMP_POWER_MISC_WMASK      = 8'h1C;
  localparam logic [7:0]  INIT_RST        = 8'h04;
  localparam logic [7:0]  INIT_WMASK      = 8'h0F;
  localparam logic [7:0]  GCLO_RST        = 8'h05;
  localparam logic [7:0]  GCLO_WMASK      = 8'h3F;
  localparam logic [7:0]  CFG_RST         = 8'h60;
  localparam logic [7:0]  CFG_WMASK       = 8'hFE;
  localparam logic [1:0]  ZDET_RST        = 2'h2;
  // zero-run thresholds in samples, indexed by the 2-bit select
  localparam logic [11:0] ZRUN_T0         = 12'd32;
  localparam logic [11:0] ZRUN_T1         = 12'd1000;
  localparam logic [11:0] ZRUN_T2         = 12'd2000;
  localparam logic [11:0] ZRUN_T3         = 12'd4000;
  // beep tone: half period in frames is 2*divider (48 kHz / (4*divider))
  localparam int          TONE_HALF_MULT  = 2;
endpackage

// ---- tb/bavr_regs_sva.sv ----
// bavr_regs_sva: link-domain checks on verb answers and beep pins.
// assumes it is bound to bavr_regs and answers come one link cycle after a verb.
`timescale 1ns/100ps
module bavr_regs_sva (
  input wire logic        i_link_clk,
  input wire logic        i_rst,
  input wire logic        i_fg_reset,
  input wire logic        i_verb_valid,
  input wire logic [6:0]  i_verb_nid,
  input wire logic [11:0] i_verb_id,
  input wire logic [7:0]  i_verb_payload,
  input wire logic [3:0]  i_pin_out_en,
  input wire logic        o_resp_valid,
  input wire logic [31:0] o_resp_data,
  input wire logic [3:0]  o_beep_pins
);
  // ------------------------------------------------------------
  // verb answers and beep pins
  // ------------------------------------------------------------
  default clocking cb_link @(posedge i_link_clk); endclocking
  default disable iff (i_rst);
  wire logic beep_verb = i_verb_valid && i_verb_nid == 7'h19;
  wire logic vend_verb = i_verb_valid && i_verb_nid == 7'h1A;
  sequence s_pwr_get;
    beep_verb && i_verb_id == 12'hF05;
  endsequence
  // a function group reset between the two gets would raise the flag again
  sequence s_get_pair;
    (beep_verb && i_verb_id == 12'hF05 && !i_fg_reset) ##1 !i_fg_reset[*2] ##1 s_pwr_get;
  endsequence
  property p_answer; beep_verb || vend_verb |=> o_resp_valid; endproperty
  property p_cause; o_resp_valid |-> $past(beep_verb) || $past(vend_verb); endproperty
  property p_pins; (o_beep_pins & ~$past(i_pin_out_en)) == 4'h0; endproperty
  property p_pwr; s_pwr_get |=> (o_resp_data & 32'hFFFF_FBCC) == 32'h0; endproperty
  // a second get three cycles on must find the cleared flag already dropped
  property p_clear; s_get_pair |=> !o_resp_data[10]; endproperty
  property p_ampcap;
    beep_verb && i_verb_id == 12'hF00 && i_verb_payload == 8'h12 |=> o_resp_data == 32'h8017_0303;
  endproperty
  property p_vend; vend_verb && i_verb_id[11:8] == 4'hF |=> o_resp_data[31:8] == 24'h0; endproperty
  property p_dgain; beep_verb && i_verb_id == 12'hF7A |=> o_resp_data <= 32'h5; endproperty
  a_answer: assert property (p_answer) else $error("verb not answered next cycle");
  a_cause: assert property (p_cause) else $error("answer without a verb");
  a_pins: assert property (p_pins) else $error("beep on a pin not set as output");
  a_pwr: assert property (p_pwr) else $error("power state reserved or error bit set");
  a_clear: assert property (p_clear) else $error("settings cleared flag not dropped");
  a_ampcap: assert property (p_ampcap) else $error("amp capability wrong");
  a_vend: assert property (p_vend) else $error("vendor reserved bits set");
  a_dgain: assert property (p_dgain) else $error("digital gain out of range");
endmodule
bind bavr_regs bavr_regs_sva i_bavr_regs_sva (.i_link_clk, .i_rst, .i_fg_reset, .i_verb_valid,
  .i_verb_nid,
  .i_verb_id, .i_verb_payload, .i_pin_out_en, .o_resp_valid, .o_resp_data, .o_beep_pins);

// ---- tb/bavr_link_host.sv ----
// bavr_link_host: link controller model issuing one verb at a time.
// assumes the codec answers one link cycle after it takes a verb.
`timescale 1ns/100ps
module bavr_link_host #(
  parameter int FRAME_CYC = 4
) (
  input  wire logic        i_link_clk,
  input  wire logic        i_resp_valid,
  input  wire logic [31:0] i_resp_data,
  output logic             o_verb_valid,
  output logic [6:0]       o_verb_nid,
  output logic [11:0]      o_verb_id,
  output logic [7:0]       o_verb_payload,
  output logic             o_frame_sync
);
  int fcnt = 0;
  initial begin
    o_verb_valid = 1'b0;
    o_verb_nid = 7'h0;
    o_verb_id = 12'h0;
    o_verb_payload = 8'h0;
  end
  // short frames keep beep periods to a few dozen link cycles
  always @(posedge i_link_clk) begin
    fcnt <= (fcnt == FRAME_CYC - 1) ? 0 : fcnt + 1;
    o_frame_sync <= (fcnt == FRAME_CYC - 1);
  end
  task automatic send(input logic [6:0] n, input logic [11:0] v, input logic [7:0] p,
                      output logic [31:0] r);
    @(posedge i_link_clk);
    o_verb_valid <= 1'b1;
    o_verb_nid <= n;
    o_verb_id <= v;
    o_verb_payload <= p;
    @(posedge i_link_clk);
    // released fields show the inverse so stale values are never trusted
    o_verb_valid <= 1'b0;
    o_verb_nid <= ~n;
    o_verb_id <= ~v;
    o_verb_payload <= ~p;
    @(posedge i_link_clk);
    r = i_resp_valid ? i_resp_data : 32'hFFFF_FFFF;
  endtask
endmodule

// ---- tb/beep_and_amp_verb_regs_test.sv ----
// beep_and_amp_verb_regs_test: verb-level tests of the beep and amp register bank.
// assumes bavr_regs, bavr_link_host and the bound checker are compiled first.
`timescale 1ns/100ps
module beep_and_amp_verb_regs_test;
  localparam logic [6:0] nb = 7'h19;
  localparam logic [6:0] nv = 7'h1A;
  localparam int         frame_cyc = 4;
  logic        i_clk = 1'b0, i_rst = 1'b1, i_link_clk = 1'b0, i_fg_reset = 1'b0;
  logic        i_ch0_saturation = 1'b0, i_ch1_saturation = 1'b0;
  logic        i_sample_strobe = 1'b0, i_sample_zero = 1'b0;
  logic [3:0]  i_pin_out_en = 4'h5;
  logic        i_verb_valid, i_frame_sync, o_resp_valid, o_beep_active, o_beep_mute, o_zero_mute;
  logic [6:0]  i_verb_nid;
  logic [11:0] i_verb_id;
  logic [7:0]  i_verb_payload, o_spk_level_left, o_spk_level_right, o_datapath_init;
  logic [7:0]  o_amp_config, o_amp_power_misc;
  logic [31:0] o_resp_data;
  logic [3:0]  o_beep_pins;
  logic [2:0]  o_beep_dgain;
  logic [1:0]  o_beep_amp_gain;
  int          n_fail = 0;
  int          checks = 0;
  always #5 i_clk = ~i_clk;
  initial begin
    #2;
    forever #15 i_link_clk = ~i_link_clk;
  end
  bavr_regs i_bavr_regs (.i_clk, .i_rst, .i_link_clk, .i_fg_reset, .i_verb_valid, .i_verb_nid,
    .i_verb_id, .i_verb_payload, .i_frame_sync, .i_ch0_saturation, .i_ch1_saturation,
    .i_sample_strobe, .i_sample_zero, .i_pin_out_en, .o_resp_valid, .o_resp_data, .o_beep_pins,
    .o_beep_active, .o_beep_dgain, .o_beep_mute, .o_beep_amp_gain, .o_spk_level_left,
    .o_spk_level_right, .o_datapath_init, .o_amp_config, .o_amp_power_misc, .o_zero_mute);
  bavr_link_host #(.FRAME_CYC(frame_cyc)) i_bavr_link_host (.i_link_clk,
    .i_resp_valid(o_resp_valid), .i_resp_data(o_resp_data), .o_verb_valid(i_verb_valid),
    .o_verb_nid(i_verb_nid), .o_verb_id(i_verb_id), .o_verb_payload(i_verb_payload),
    .o_frame_sync(i_frame_sync));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic vb(input logic [6:0] n, input logic [11:0] v, input logic [7:0] p,
                    input logic [31:0] exp);
    logic [31:0] r;
    i_bavr_link_host.send(n, v, p, r);
    cmp($sformatf("verb %h", v), exp, r);
  endtask
  task automatic hold_while(input logic lvl, output int n);
    n = 0;
    while (o_beep_pins[0] === lvl && n < 500) begin
      @(posedge i_link_clk);
      n++;
    end
  endtask
  task automatic samples(input int cnt);
    repeat (cnt) begin
      @(posedge i_link_clk);
      i_sample_strobe <= 1'b1;
      i_sample_zero <= 1'b1;
    end
    @(posedge i_link_clk);
    i_sample_strobe <= 1'b0;
  endtask
  task automatic core_wait;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #50000;
    n_fail++;
    test_done();
  end
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    int n;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_link_clk);
    vb(nb, 12'hF05, 8'h00, 32'h430);
    vb(nb, 12'hF05, 8'h00, 32'h30);
    vb(nb, 12'h705, 8'h02, 32'h0);
    vb(nb, 12'hF05, 8'h00, 32'h22);
    vb(nb, 12'hF00, 8'h12, 32'h8017_0303);
    vb(nb, 12'hBA0, 8'h00, 32'h1);
    vb(nb, 12'h3A0, 8'hFF, 32'h0);
    vb(nb, 12'hBA0, 8'h00, 32'h83);
    vb(nb, 12'hF7A, 8'h00, 32'h5);
    vb(nb, 12'h77A, 8'h03, 32'h0);
    vb(nb, 12'h77A, 8'h07, 32'h0);
    vb(nb, 12'hF7A, 8'h00, 32'h3);
    vb(nv, 12'hF71, 8'h00, 32'h30);
    vb(nv, 12'h773, 8'hAB, 32'h0);
    vb(nv, 12'h771, 8'h11, 32'h0);
    vb(nv, 12'hF72, 8'h00, 32'hAB);
    vb(nv, 12'h779, 8'hFF, 32'h0);
    vb(nv, 12'hF79, 8'h00, 32'h1E);
    vb(nv, 12'hF81, 8'h00, 32'h4);
    vb(nv, 12'h781, 8'hFF, 32'h0);
    vb(nv, 12'hF81, 8'h00, 32'hF);
    vb(nv, 12'hF82, 8'h00, 32'h60);
    vb(nv, 12'h782, 8'h5B, 32'h0);
    vb(nv, 12'hF82, 8'h00, 32'h5A);
    core_wait();
    cmp("dgain", 32'h3, 32'(o_beep_dgain));
    cmp("amp", 32'h7, 32'({o_beep_mute, o_beep_amp_gain}));
    cmp("left", 32'h11, 32'(o_spk_level_left));
    cmp("right", 32'hAB, 32'(o_spk_level_right));
    cmp("init", 32'hF, 32'(o_datapath_init));
    cmp("config", 32'h5A, 32'(o_amp_config));
    cmp("power misc", 32'h1E, 32'(o_amp_power_misc));
    vb(nv, 12'h77F, 8'h00, 32'h0);
    vb(nv, 12'hF82, 8'h00, 32'h60);
    vb(nv, 12'hF72, 8'h00, 32'h30);
    vb(nv, 12'hF81, 8'h00, 32'h4);
    vb(nb, 12'hF7A, 8'h00, 32'h3);
    vb(nv, 12'hF33, 8'h00, 32'h0);
    vb(7'h10, 12'hF05, 8'h00, 32'hFFFF_FFFF);
    i_ch0_saturation <= 1'b1;
    i_ch1_saturation <= 1'b1;
    repeat (4) @(posedge i_link_clk);
    vb(nv, 12'hF80, 8'h00, 32'hC6);
    i_ch0_saturation <= 1'b0;
    i_ch1_saturation <= 1'b0;
    repeat (4) @(posedge i_link_clk);
    vb(nv, 12'hF80, 8'h00, 32'hC0);
    vb(nv, 12'h791, 8'h84, 32'h0);
    vb(nv, 12'hF80, 8'h00, 32'h0);
    vb(nv, 12'h790, 8'h05, 32'h0);
    samples(32);
    vb(nv, 12'hF80, 8'h00, 32'h0);
    samples(1);
    vb(nv, 12'hF80, 8'h00, 32'h1);
    core_wait();
    cmp("zero mute", 32'h1, 32'(o_zero_mute));
    vb(nb, 12'h70A, 8'h02, 32'h0);
    hold_while(1'b1, n);
    hold_while(1'b0, n);
    hold_while(1'b1, n);
    cmp("tone half period", 32'(2 * 2 * frame_cyc), 32'(n));
    cmp("beep active", 32'h1, 32'(o_beep_active));
    vb(nb, 12'h70A, 8'h00, 32'h0);
    repeat (20) @(posedge i_link_clk);
    cmp("beep pins", 32'h0, 32'(o_beep_pins));
    vb(nv, 12'h771, 8'h22, 32'h0);
    i_fg_reset <= 1'b1;
    @(posedge i_link_clk);
    i_fg_reset <= 1'b0;
    vb(nb, 12'hF05, 8'h00, 32'h430);
    vb(nv, 12'hF71, 8'h00, 32'h30);
    vb(nb, 12'hF7A, 8'h00, 32'h5);
    test_done();
  end
endmodule
